/* File: design/bsc_pkg.sv */
// types for the burner sequence controller
package bsc_pkg;
  typedef enum logic [3:0] {
    BSC_INIT,
    BSC_HOLD,
    BSC_STANDBY,
    BSC_PREPURGE,
    BSC_PILOT,
    BSC_MAIN,
    BSC_RUN,
    BSC_POSTPURGE,
    BSC_LOCKOUT
  } bsc_state_e;
endpackage : bsc_pkg

/* File: design/bsc_regs.svh */
// timing constants and fault codes for the burner sequence controller
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH
`define BSC_CLK_HZ 100000000
`define BSC_TICK_CYCLES (`BSC_CLK_HZ / 1)
`define BSC_INIT_S 16'd10
`define BSC_HOLD_MIN_S 16'd5
`define BSC_HOLD_LOCK_MIN 16'd4
`define BSC_HOLD_LOCK_S (`BSC_HOLD_LOCK_MIN * 16'd60)
`define BSC_PURGE_MIN_S 16'd2
`define BSC_PURGE_MAX_MIN 16'd30
`define BSC_PURGE_MAX_S (`BSC_PURGE_MAX_MIN * 16'd60)
`define BSC_AIRFLOW_S 16'd10
`define BSC_PILOT_LONG_S 16'd10
`define BSC_PILOT_SHORT_S 16'd4
`define BSC_TEST_LONG_S 16'd8
`define BSC_TEST_SHORT_S 16'd3
`define BSC_TEST_FLAMEOUT_S 16'd15
`define BSC_MAIN_TRIAL_S 16'd10
`define BSC_POSTPURGE_S 16'd15
`define BSC_STBY_FLAME_S 16'd30
`define BSC_FLR_FAST_MS 16'd800
`define BSC_FLR_SLOW_MS 16'd3000
`define BSC_MS_CYCLES (`BSC_CLK_HZ / 1000)
`define BSC_CFG_LOCK_H 32'd200
`define BSC_CFG_LOCK_S (`BSC_CFG_LOCK_H * 32'd3600)
`define BSC_FAULT_NONE 8'h00
`define BSC_FAULT_LINE 8'h01
`define BSC_FAULT_CARD 8'h02
`define BSC_FAULT_AIRFLOW 8'h03
`define BSC_FAULT_STBY_FLAME 8'h04
`define BSC_FAULT_FEEDBACK 8'h05
`define BSC_FAULT_NO_FLAME 8'h06
`define BSC_FAULT_FLAMEOUT 8'h07
`define BSC_FAULT_CONFIG 8'h6e
`endif

/* File: design/bsc_sync.sv */
// two-flop synchroniser bank for the field inputs
`timescale 1ns/1ps
module bsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // asynchronous inputs and synchronised copies
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (reset) begin
          meta_q[i] <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          meta_q[i] <= asyncIn[i];
          syncOut[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule : bsc_sync

/* File: design/burner_sequence_controller.sv */
// burner safety sequencer: states, timers, outputs and lockout
// Functional notes
// - after power-up spend ten seconds in initial check before standby.
// - line voltage or frequency out of tolerance in any state but lockout enters hold.
// - hold and flag at least five seconds, then restart initial check from zero.
// - tolerance hold lasting four minutes causes lockout.
// - leave standby only with call for heat and all interlocks correct.
// - prepurge length chosen by purge card, two seconds to thirty minutes.
// - blower motor output energized from start of prepurge.
// - airflow closed by ten seconds; else recycle prepurge or lockout per jumper.
// - pilot trial energizes pilot valve and ignition outputs.
// - no flame at end of ten or four second pilot trial means shutdown.
// - flame proven in pilot trial de-energizes ignition.
// - main valve on after pilot trial; flameout locks out or recycles in 0.8/3 s.
// - two-stage runs ten second main trial, then drops interrupted pilot.
// - two-stage energizes delayed main valve on entering run.
// - stay in run until call for heat opens.
// - postpurge drops fuel outputs and keeps blower on fifteen seconds.
// - test switch freezes measured prepurge timer.
// - test switch stops pilot timer in first eight or three seconds.
// - pilot trial held in test runs fifteen second flameout timer.
// - standby flame still present after 30 seconds causes lockout.
// - standby or prepurge feedback of energized fuel or ignition causes lockout.
// - run with ignition sensed on or main valve sensed off causes lockout.
// - missing, removed or faulty purge card causes lockout in any state.
// - jumper change after 200 hours raises fault 110, not resettable; here the fault latch clears with reset.
`timescale 1ns/1ps
`include "bsc_regs.svh"
module burner_sequence_controller
  import bsc_pkg::*;
#(
  parameter int TICK_CYCLES = `BSC_TICK_CYCLES,
  parameter int MS_CYCLES = `BSC_MS_CYCLES,
  parameter logic [31:0] CFG_LOCK_S = `BSC_CFG_LOCK_S
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // variant straps
  input wire logic twoStageVariant,
  input wire logic postpurgeVariant,
  // line monitor
  input wire logic lineVoltageOk,
  input wire logic lineFreqOk,
  // field inputs
  input wire logic callForHeat,
  input wire logic limitsOk,
  input wire logic airflowInterlock,
  input wire logic flameSensed,
  input wire logic testSwitch,
  // purge card
  input wire logic purgeCardPresent,
  input wire logic purgeCardFault,
  input wire logic [15:0] purgeCardSeconds,
  // jumpers and amplifier
  input wire logic pilotTrialLengthJumper,
  input wire logic flameFailActionJumper,
  input wire logic airflowFailActionJumper,
  input wire logic slowFlameResponse,
  // output feedback
  input wire logic ignitionFb,
  input wire logic pilotFb,
  input wire logic mainFb,
  input wire logic delayedMainFb,
  // load outputs
  output logic motorOut,
  output logic ignitionOut,
  output logic pilotOut,
  output logic mainOut,
  output logic delayedMainOut,
  // status
  output logic holdFlag,
  output logic lockoutFlag,
  output logic [3:0] stateCode,
  output logic [7:0] faultCode
);
  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  localparam int NSYNC = 18;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncIn;
  logic vOk, fOk, cfh, lim, air, flame, tst, cardIn, cardBad, jPilot, jFlame, jAir, slowAmp;
  logic fbIgn, fbPilot, fbMain, fbDly;
  logic [15:0] purgeSel_q;

  assign rawIn = {lineVoltageOk, lineFreqOk, callForHeat, limitsOk, airflowInterlock, flameSensed,
                  testSwitch, purgeCardPresent, purgeCardFault, pilotTrialLengthJumper,
                  flameFailActionJumper, airflowFailActionJumper, slowFlameResponse,
                  ignitionFb, pilotFb, mainFb, delayedMainFb, 1'b0};
  assign {vOk, fOk, cfh, lim, air, flame, tst, cardIn, cardBad, jPilot, jFlame, jAir, slowAmp,
          fbIgn, fbPilot, fbMain, fbDly} = syncIn[NSYNC-1:1];

  bsc_sync #(.W(NSYNC)) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );

  // card timing is quasi-static; two-stage capture keeps it off the raw pins
  logic [15:0] purgeMeta_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      purgeMeta_q <= 16'h0000;
      purgeSel_q <= 16'h0000;
    end else begin
      purgeMeta_q <= purgeCardSeconds;
      purgeSel_q <= purgeMeta_q;
    end
  end

  // ----------------------------------------
  // one second and one millisecond ticks
  // ----------------------------------------
  logic [31:0] tickCnt_q;
  logic secTick;
  logic [31:0] msCnt_q;
  logic msTick;
  logic entry;
  assign secTick = (tickCnt_q == 32'(TICK_CYCLES - 1));
  assign msTick = (msCnt_q == 32'(MS_CYCLES - 1));

  // restarting on entry makes every period timed by secs_q whole seconds; the hour count drifts slightly
  always_ff @(posedge core_clk) begin
    if (reset || secTick || entry) begin
      tickCnt_q <= 32'h0;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || msTick) begin
      msCnt_q <= 32'h0;
    end else begin
      msCnt_q <= msCnt_q + 32'h1;
    end
  end

  // ----------------------------------------
  // state machine and timers
  // ----------------------------------------
  bsc_state_e state_q, state_d;
  logic [15:0] secs_q;
  logic [15:0] aux_q;
  logic [15:0] flameLossMs_q;
  logic [15:0] holdTotal_q;
  logic refTaken_q;
  logic lineOk, cardOk, lockReq;
  logic [7:0] lockCode;
  logic [15:0] purgeLen, pilotLen, testStop, flrMs;
  logic cfgFault_q;

  assign lineOk = vOk && fOk;
  assign cardOk = cardIn && !cardBad;
  assign entry = (state_d != state_q);
  assign purgeLen = (purgeSel_q < `BSC_PURGE_MIN_S) ? `BSC_PURGE_MIN_S :
                    (purgeSel_q > `BSC_PURGE_MAX_S) ? `BSC_PURGE_MAX_S : purgeSel_q;
  assign pilotLen = jPilot ? `BSC_PILOT_LONG_S : `BSC_PILOT_SHORT_S;
  assign testStop = jPilot ? `BSC_TEST_LONG_S : `BSC_TEST_SHORT_S;
  assign flrMs = slowAmp ? `BSC_FLR_SLOW_MS : `BSC_FLR_FAST_MS;

  // feedback trails a load change by the output flop and two sync stages
  logic [1:0] fbWait_q;
  logic fbSettled;
  assign fbSettled = (fbWait_q == 2'h3);
  always_ff @(posedge core_clk) begin
    if (reset || entry) begin
      fbWait_q <= 2'h0;
    end else if (!fbSettled) begin
      fbWait_q <= fbWait_q + 2'h1;
    end
  end

  // lockout request and next state
  always_comb begin
    state_d = state_q;
    lockReq = 1'b0;
    lockCode = `BSC_FAULT_NONE;
    case (state_q)
      BSC_INIT: begin
        if (secTick && secs_q + 16'h1 >= `BSC_INIT_S) begin
          state_d = BSC_STANDBY;
        end
      end
      BSC_HOLD: begin
        if (holdTotal_q >= `BSC_HOLD_LOCK_S) begin
          lockReq = 1'b1;
          lockCode = `BSC_FAULT_LINE;
        end else if (lineOk && secs_q >= `BSC_HOLD_MIN_S) begin
          state_d = BSC_INIT;
        end
      end
      BSC_STANDBY: begin
        if (fbSettled && (fbIgn || fbPilot || fbMain || fbDly)) begin
          lockReq = 1'b1;
          lockCode = `BSC_FAULT_FEEDBACK;
        end else if (flame && aux_q >= `BSC_STBY_FLAME_S) begin
          lockReq = 1'b1;
          lockCode = `BSC_FAULT_STBY_FLAME;
        end else if (cfh && lim && !flame) begin
          state_d = BSC_PREPURGE;
        end
      end
      BSC_PREPURGE: begin
        if (fbSettled && (fbIgn || fbPilot || fbMain || fbDly)) begin
          lockReq = 1'b1;
          lockCode = `BSC_FAULT_FEEDBACK;
        end else if (!cfh || !lim) begin
          state_d = BSC_STANDBY;
        end else if (!air && secs_q >= `BSC_AIRFLOW_S) begin
          if (jAir) begin
            state_d = BSC_STANDBY;
          end else begin
            lockReq = 1'b1;
            lockCode = `BSC_FAULT_AIRFLOW;
          end
        end else if (air && aux_q >= purgeLen) begin
          state_d = BSC_PILOT;
        end
      end
      BSC_PILOT: begin
        if (!flame && tst && aux_q >= `BSC_TEST_FLAMEOUT_S) begin
          lockReq = 1'b1;
          lockCode = `BSC_FAULT_NO_FLAME;
        end else if (secs_q >= pilotLen) begin
          if (flame) begin
            state_d = twoStageVariant ? BSC_MAIN : BSC_RUN;
          end else begin
            lockReq = 1'b1;
            lockCode = `BSC_FAULT_NO_FLAME;
          end
        end
      end
      BSC_MAIN: begin
        if (secs_q >= `BSC_MAIN_TRIAL_S) begin
          state_d = BSC_RUN;
        end
      end
      BSC_RUN: begin
        if (fbSettled && (fbIgn || !fbMain || (twoStageVariant && fbPilot))) begin
          lockReq = 1'b1;
          lockCode = `BSC_FAULT_FEEDBACK;
        end else if (!cfh) begin
          state_d = postpurgeVariant ? BSC_POSTPURGE : BSC_STANDBY;
        end
      end
      BSC_POSTPURGE: begin
        if (secs_q >= `BSC_POSTPURGE_S) begin
          state_d = BSC_STANDBY;
        end
      end
      BSC_LOCKOUT: begin
        state_d = BSC_LOCKOUT;
      end
      default: begin
        state_d = BSC_LOCKOUT;
      end
    endcase
    // flameout during main trial or run
    if ((state_q == BSC_MAIN || state_q == BSC_RUN) && !flame && flameLossMs_q >= flrMs) begin
      if (jFlame) begin
        state_d = BSC_STANDBY;
        lockReq = 1'b0;
      end else begin
        lockReq = 1'b1;
        lockCode = `BSC_FAULT_FLAMEOUT;
      end
    end
    if (state_q != BSC_LOCKOUT && !lineOk && state_q != BSC_HOLD) begin
      state_d = BSC_HOLD;
      lockReq = 1'b0;
    end
    if (state_q != BSC_LOCKOUT && !cardOk) begin
      lockReq = 1'b1;
      lockCode = `BSC_FAULT_CARD;
    end
    if (cfgFault_q) begin
      lockReq = 1'b1;
      lockCode = `BSC_FAULT_CONFIG;
    end
    if (!refTaken_q) begin
      state_d = state_q; // sync outputs read zero until filled, so nothing is judged yet
      lockReq = 1'b0;
    end
    if (lockReq) begin
      state_d = BSC_LOCKOUT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= BSC_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // main sequence seconds timer, frozen in test where allowed
  logic freeze;
  assign freeze = tst && state_q == BSC_PILOT && secs_q < testStop;
  always_ff @(posedge core_clk) begin
    if (reset || entry) begin
      secs_q <= 16'h0;
    end else if (secTick && !freeze && secs_q != 16'hffff) begin
      secs_q <= secs_q + 16'h1;
    end
  end

  // auxiliary timer: standby flame, prepurge measure, test flameout
  always_ff @(posedge core_clk) begin
    if (reset || entry) begin
      aux_q <= 16'h0;
    end else if (state_q == BSC_STANDBY && !flame) begin
      aux_q <= 16'h0;
    end else if (state_q == BSC_PREPURGE && (!air || tst)) begin
      aux_q <= aux_q;
    end else if (state_q == BSC_PILOT && (flame || !tst)) begin
      aux_q <= 16'h0;
    end else if (secTick && aux_q != 16'hffff) begin
      aux_q <= aux_q + 16'h1;
    end
  end

  // accumulated hold time survives the brief restarts of initial check
  always_ff @(posedge core_clk) begin
    if (reset || state_q == BSC_STANDBY) begin
      holdTotal_q <= 16'h0;
    end else if (state_q == BSC_HOLD && secTick && holdTotal_q != 16'hffff) begin
      holdTotal_q <= holdTotal_q + 16'h1;
    end
  end

  // flame loss timer in milliseconds for response time
  always_ff @(posedge core_clk) begin
    if (reset || entry || flame) begin
      flameLossMs_q <= 16'h0;
    end else if (msTick && flameLossMs_q != 16'hffff) begin
      flameLossMs_q <= flameLossMs_q + 16'h1;
    end
  end

  // ----------------------------------------
  // configuration jumper watch
  // ----------------------------------------
  logic [31:0] runSecs_q;
  logic [2:0] jumperRef_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      runSecs_q <= 32'h0;
    end else if (secTick && runSecs_q != 32'hffffffff) begin
      runSecs_q <= runSecs_q + 32'h1;
    end
  end

  // reference taken once the synchronisers hold real pin values, never under reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      refTaken_q <= 1'b0;
      jumperRef_q <= 3'h0;
    end else if (!refTaken_q && fbWait_q == 2'h2) begin
      refTaken_q <= 1'b1;
      jumperRef_q <= {jPilot, jFlame, jAir};
    end
  end

  // limitation: the hour count and this latch clear with reset, as nothing is nonvolatile here
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfgFault_q <= 1'b0;
    end else if (refTaken_q && runSecs_q >= CFG_LOCK_S && {jPilot, jFlame, jAir} != jumperRef_q) begin
      cfgFault_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // outputs and status
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      motorOut <= 1'b0;
      ignitionOut <= 1'b0;
      pilotOut <= 1'b0;
      mainOut <= 1'b0;
      delayedMainOut <= 1'b0;
    end else begin
      motorOut <= state_d inside {BSC_PREPURGE, BSC_PILOT, BSC_MAIN, BSC_RUN, BSC_POSTPURGE};
      ignitionOut <= state_d == BSC_PILOT && !flame;
      pilotOut <= state_d == BSC_PILOT || state_d == BSC_MAIN ||
                  (state_d == BSC_RUN && !twoStageVariant);
      mainOut <= state_d == BSC_MAIN || state_d == BSC_RUN;
      delayedMainOut <= state_d == BSC_RUN && twoStageVariant;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      faultCode <= `BSC_FAULT_NONE;
    end else if (lockReq && state_q != BSC_LOCKOUT) begin
      faultCode <= lockCode;
    end else if (cfgFault_q) begin
      faultCode <= `BSC_FAULT_CONFIG;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      holdFlag <= 1'b0;
      lockoutFlag <= 1'b0;
      stateCode <= 4'h0;
    end else begin
      holdFlag <= state_d == BSC_HOLD;
      lockoutFlag <= state_d == BSC_LOCKOUT;
      stateCode <= state_d;
    end
  end
endmodule : burner_sequence_controller

/* File: sim/bsc_far_side.sv */
// far-side model: airflow switch, flame amplifier and load feedback
`timescale 1ns/1ps
module bsc_far_side #(
  parameter int AIR_DELAY = 20,
  parameter int FLAME_DELAY = 15
) (
  // clock
  input wire logic core_clk,
  // scenario knobs
  input wire logic airEnable,
  input wire logic flameEnable,
  // loads driven by the sequencer
  input wire logic motorOut,
  input wire logic ignitionOut,
  input wire logic pilotOut,
  input wire logic mainOut,
  input wire logic delayedMainOut,
  // sensed back by the sequencer
  output logic airflowInterlock,
  output logic flameSensed,
  output logic ignitionFb,
  output logic pilotFb,
  output logic mainFb,
  output logic delayedMainFb
);
  int airCnt = 0;
  int flameCnt = 0;
  always @(posedge core_clk) begin
    airCnt <= motorOut ? airCnt + 1 : 0;
    flameCnt <= (pilotOut | mainOut) ? flameCnt + 1 : 0;
  end
  // switch and flame lag their cause, so the sequencer never sees them at once
  assign airflowInterlock = airEnable && airCnt >= AIR_DELAY;
  assign flameSensed = flameEnable && flameCnt >= FLAME_DELAY;
  // terminals follow drives without lag: no false feedback faults
  assign ignitionFb = ignitionOut;
  assign pilotFb = pilotOut;
  assign mainFb = mainOut;
  assign delayedMainFb = delayedMainOut;
endmodule : bsc_far_side

/* File: sim/bsc_properties.sv */
// concurrent checks on the burner sequencer ports
`timescale 1ns/1ps
module bsc_properties #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // watched inputs
  input wire logic twoStageVariant,
  input wire logic purgeCardPresent,
  input wire logic flameSensed,
  // watched outputs
  input wire logic motorOut,
  input wire logic ignitionOut,
  input wire logic pilotOut,
  input wire logic mainOut,
  input wire logic delayedMainOut,
  input wire logic holdFlag,
  input wire logic lockoutFlag,
  input wire logic [3:0] stateCode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // cycles spent in initial check since release or since the last return to it
  logic [31:0] initCnt_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      initCnt_q <= 32'h0;
    end else begin
      initCnt_q <= (stateCode == 4'h0) ? initCnt_q + 32'h1 : 32'h0;
    end
  end
  // --------------------------------
  // sequences
  // --------------------------------
  sequence flameSteady;
    flameSensed [*5];
  endsequence
  sequence pilotEntry;
    stateCode == 4'h4 && $past(stateCode) != 4'h4;
  endsequence
  init_length_a: assert property (stateCode == 4'h2 && $past(stateCode) == 4'h0 |->
    initCnt_q >= 32'(9 * TICK_CYCLES)) else $error("initial check too short");
  hold_flag_a: assert property (holdFlag == (stateCode == 4'h1)) else $error("hold flag wrong");
  purge_motor_a: assert property (stateCode == 4'h3 |-> ##1 stateCode != 4'h3 || motorOut)
    else $error("blower off in prepurge");
  pilot_entry_a: assert property (pilotEntry |-> pilotOut && ignitionOut)
    else $error("pilot trial loads off");
  ign_drop_a: assert property (flameSteady ##0 stateCode == 4'h4 |-> !ignitionOut)
    else $error("ignition on with flame");
  delayed_main_a: assert property (stateCode == 4'h6 && twoStageVariant |-> delayedMainOut && !pilotOut)
    else $error("run loads wrong");
  post_blower_a: assert property (stateCode == 4'h7 |-> motorOut && !pilotOut && !mainOut && !delayedMainOut)
    else $error("postpurge loads wrong");
  standby_fuel_a: assert property (stateCode == 4'h2 |-> !(ignitionOut | pilotOut | mainOut | delayedMainOut))
    else $error("fuel load on in standby");
  card_lock_a: assert property ($fell(purgeCardPresent) |-> ##[1:6] lockoutFlag)
    else $error("no lockout on card removal");
  lock_dark_a: assert property (lockoutFlag |-> !(motorOut | ignitionOut | pilotOut | mainOut | delayedMainOut))
    else $error("load on in lockout");
  lock_latch_a: assert property (lockoutFlag |=> lockoutFlag) else $error("lockout released");
endmodule : bsc_properties

bind burner_sequence_controller bsc_properties #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .core_clk(core_clk), .reset(reset), .twoStageVariant(twoStageVariant),
  .purgeCardPresent(purgeCardPresent), .flameSensed(flameSensed), .motorOut(motorOut),
  .ignitionOut(ignitionOut), .pilotOut(pilotOut), .mainOut(mainOut), .delayedMainOut(delayedMainOut),
  .holdFlag(holdFlag), .lockoutFlag(lockoutFlag), .stateCode(stateCode)
);

/* File: sim/test_burner_sequence_controller.sv */
// testbench for the burner sequence controller
`timescale 1ns/1ps
module test_burner_sequence_controller;
  import bsc_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, callForHeat = 1'b0, lineVoltageOk = 1'b1, lineFreqOk = 1'b1;
  logic purgeCardPresent = 1'b1, pilotLenJ = 1'b1, airJ = 1'b1, airEn = 1'b1, flameEn = 1'b1;
  logic testSwitch = 1'b0, limitsOk = 1'b1, cardFault = 1'b0, flameJ = 1'b1, slowFlame = 1'b0;
  logic twoStage = 1'b1, postEn = 1'b1;
  logic air, flame, ignFb, pilFb, mainFb, dmFb, motorOut, ignitionOut, pilotOut, mainOut, delayedMainOut;
  logic holdFlag, lockoutFlag;
  logic [3:0] stateCode;
  logic [7:0] faultCode;
  int fails = 0, compares = 0, cycles = 0;
  always #5 core_clk = ~core_clk;
  burner_sequence_controller #(.TICK_CYCLES(10), .MS_CYCLES(2), .CFG_LOCK_S(32'd20)) i_dut (
    .core_clk(core_clk), .reset(reset), .twoStageVariant(twoStage), .postpurgeVariant(postEn),
    .lineVoltageOk(lineVoltageOk), .lineFreqOk(lineFreqOk), .callForHeat(callForHeat), .limitsOk(limitsOk),
    .airflowInterlock(air), .flameSensed(flame), .testSwitch(testSwitch), .purgeCardPresent(purgeCardPresent),
    .purgeCardFault(cardFault), .purgeCardSeconds(16'h0003), .pilotTrialLengthJumper(pilotLenJ),
    .flameFailActionJumper(flameJ), .airflowFailActionJumper(airJ), .slowFlameResponse(slowFlame),
    .ignitionFb(ignFb), .pilotFb(pilFb), .mainFb(mainFb), .delayedMainFb(dmFb), .motorOut(motorOut),
    .ignitionOut(ignitionOut), .pilotOut(pilotOut), .mainOut(mainOut), .delayedMainOut(delayedMainOut),
    .holdFlag(holdFlag), .lockoutFlag(lockoutFlag), .stateCode(stateCode), .faultCode(faultCode));
  bsc_far_side i_far (.core_clk(core_clk), .airEnable(airEn), .flameEnable(flameEn), .motorOut(motorOut),
    .ignitionOut(ignitionOut), .pilotOut(pilotOut), .mainOut(mainOut), .delayedMainOut(delayedMainOut),
    .airflowInterlock(air), .flameSensed(flame), .ignitionFb(ignFb), .pilotFb(pilFb), .mainFb(mainFb),
    .delayedMainFb(dmFb));
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic wrap_up();
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // bounded wait; a miss shows up as a state mismatch
  task automatic wait_state(input logic [3:0] s, input int lim, output int took);
    took = 0;
    while (stateCode !== s && took < lim) begin
      @(posedge core_clk);
      #1;
      took++;
    end
    check({4'h0, stateCode}, {4'h0, s});
  endtask : wait_state
  // jumpers only move under reset, so no configuration fault is provoked
  task automatic restart(input logic lenJ, input logic aJ, input logic aEn, input logic fEn, input logic [2:0] v);
    int took;
    @(posedge core_clk);
    reset <= 1'b1;
    pilotLenJ <= lenJ;
    airJ <= aJ;
    airEn <= aEn;
    flameEn <= fEn;
    {twoStage, postEn, flameJ} <= v;
    callForHeat <= 1'b0;
    lineVoltageOk <= 1'b1;
    purgeCardPresent <= 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    check({stateCode, motorOut, ignitionOut, pilotOut, mainOut}, 8'h00);
    wait_state(4'h2, 200, took);
    check(8'(took >= 90), 8'h01);
  endtask : restart
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    int took;
    restart(1'b1, 1'b1, 1'b1, 1'b1, 3'h7);
    @(posedge core_clk) callForHeat <= 1'b1;
    wait_state(4'h3, 10, took);
    @(posedge core_clk);
    #1 check({7'h0, motorOut}, 8'h01);
    wait_state(4'h4, 200, took);
    check(8'(took >= 28), 8'h01);
    check({6'h0, pilotOut, ignitionOut}, 8'h03);
    repeat (25) @(posedge core_clk);
    #1 check({6'h0, pilotOut, ignitionOut}, 8'h02);
    wait_state(4'h5, 120, took);
    check({7'h0, mainOut}, 8'h01);
    wait_state(4'h6, 120, took);
    check(8'(took >= 90), 8'h01);
    check({6'h0, pilotOut, delayedMainOut}, 8'h01);
    repeat (50) @(posedge core_clk);
    #1 check({4'h0, stateCode}, 8'h06);
    @(posedge core_clk) callForHeat <= 1'b0;
    wait_state(4'h7, 10, took);
    check({4'h0, motorOut, pilotOut, mainOut, delayedMainOut}, 8'h08);
    wait_state(4'h2, 200, took);
    check(8'(took >= 140), 8'h01);
    @(posedge core_clk) lineFreqOk <= 1'b0;
    wait_state(4'h1, 10, took);
    check({7'h0, holdFlag}, 8'h01);
    @(posedge core_clk) lineFreqOk <= 1'b1;
    wait_state(4'h0, 100, took);
    check(8'(took >= 45), 8'h01);
    wait_state(4'h2, 200, took);
    @(posedge core_clk) lineVoltageOk <= 1'b0;
    wait_state(4'h8, 2600, took);
    check(8'(took >= 2350), 8'h01);
    check(faultCode, 8'h01);
    // short trial, no flame ever
    restart(1'b0, 1'b1, 1'b1, 1'b0, 3'h7);
    @(posedge core_clk) callForHeat <= 1'b1;
    wait_state(4'h4, 200, took);
    wait_state(4'h8, 80, took);
    check(8'(took >= 35 && took <= 55), 8'h01);
    check(faultCode, 8'h06);
    // airflow never closes, failure jumper clipped
    restart(1'b1, 1'b0, 1'b0, 1'b1, 3'h7);
    @(posedge core_clk) callForHeat <= 1'b1;
    wait_state(4'h3, 10, took);
    wait_state(4'h8, 130, took);
    check(8'(took >= 90), 8'h01);
    check(faultCode, 8'h03);
    // single stage, no postpurge, flameout in run with the failure jumper clipped
    restart(1'b1, 1'b1, 1'b1, 1'b1, 3'h0);
    @(posedge core_clk) callForHeat <= 1'b1;
    wait_state(4'h4, 200, took);
    wait_state(4'h6, 120, took);
    check({5'h0, pilotOut, mainOut, delayedMainOut}, 8'h06);
    @(posedge core_clk) flameEn <= 1'b0;
    wait_state(4'h8, 1700, took);
    check(8'(took >= 1590 && took <= 1610), 8'h01);
    check(faultCode, 8'h07);
    restart(1'b1, 1'b1, 1'b1, 1'b1, 3'h7);
    @(posedge core_clk) purgeCardPresent <= 1'b0;
    wait_state(4'h8, 10, took);
    check(faultCode, 8'h02);
    check({3'h0, motorOut, ignitionOut, pilotOut, mainOut, delayedMainOut}, 8'h00);
    wrap_up();
  end
endmodule : test_burner_sequence_controller
